/* File: core/dur_pkg.sv */
// package: register map, field positions and carrier types of the channel register bank
package dur_pkg;
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_IEN = 3'h1;
  localparam logic [2:0] ADDR_ISTAT = 3'h2;
  localparam logic [2:0] ADDR_LCTL = 3'h3;
  localparam logic [2:0] ADDR_MCTL = 3'h4;
  localparam logic [2:0] ADDR_LSTAT = 3'h5;
  localparam logic [2:0] ADDR_MSTAT = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;
  localparam logic [7:0] ENH_BANK_KEY = 8'hBF;
  localparam int LCTL_DIV_BIT = 7;
  localparam int LCTL_BREAK_BIT = 6;
  localparam int MCTL_DTR_BIT = 0;
  localparam int MCTL_RTS_BIT = 1;
  localparam int MCTL_OUT1_BIT = 2;
  localparam int MCTL_OUT2_BIT = 3;
  localparam int MCTL_LOOP_BIT = 4;
  localparam int EFR_UNLOCK_BIT = 4;
  localparam int EFR_ARTS_BIT = 6;
  localparam int EFR_ACTS_BIT = 7;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;
  localparam logic [7:0] IEN_BASE_MASK = 8'h0F;
  localparam logic [7:0] ISTAT_BASE_MASK = 8'hCF;
  localparam logic [7:0] FCR_BASE_MASK = 8'hCF;
  localparam logic [7:0] MCTL_BASE_MASK = 8'h1F;
  localparam logic [7:0] FRAC_MASK = 8'h3F;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam logic [7:0] LCTL_RESET = 8'h03;
  localparam logic [7:0] FRAC_RESET = 8'h00;
  localparam logic [7:0] DIV_LOW_RESET = 8'h01;
  localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
  localparam logic [7:0] CHAR_RESET = 8'h00;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic ri_n;
    logic cd_n;
  } dur_modem_in_s;

  typedef struct packed {
    logic tx;
    logic rts_n;
    logic dtr_n;
    logic out1_n;
    logic out2_n;
  } dur_line_out_s;

  typedef struct packed {
    logic [7:0] ien;
    logic [7:0] fifo_control;
    logic [7:0] lctl;
    logic [7:0] mctl;
    logic [7:0] scratch;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] frac;
    logic [7:0] enhanced_function;
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] xoff2;
  } dur_regs_s;
endpackage : dur_pkg

/* File: core/dur_channel.sv */
// one channel of the dual serial port: register bank, banking and internal loopback
// Notes on behaviour
// - loopback is active while modem control bit 4 is one.
// - in loopback the transmit shift output feeds the receive shift input.
// - in loopback tx, request and ready pins hold; modem inputs are ignored.
// - normal functions, status and interrupts keep working during loopback.
// - automatic request/clear flow control is left inactive in loopback.
// - each channel has its own bank, chosen by three address bits and select.
// - address 0 normal bank: read receive byte, write transmit byte.
// - divisor bank: address 0 divisor low, address 1 divisor high, read/write.
// - fraction register at address 2 in divisor bank when enhanced unlock set.
// - divisor zero: addresses 0 and 1 read revision and identification codes.
// - address 1 normal bank holds the interrupt enables.
// - address 2 reads interrupt status; bits 7-6 show FIFOs enabled.
// - address 2 writes FIFO control: enable, resets, DMA, triggers.
// - line control at address 3 always reachable.
// - modem control at address 4 drives ready, request, outputs and loopback.
// - address 5 reads line status flags.
// - address 6 reads modem change flags low and input states high.
// - address 7 is a scratch byte with no effect.
// - line control 0xBF: enhanced register and the four flow characters.
// - enhanced-only bits write only when unlock set, else read zero.
// - enhanced register: flow select, unlock, special char, auto request, auto clear.
`timescale 1ns/1ns
`default_nettype none
module dur_channel #(
  parameter logic [7:0] REVISION_CODE = 8'h01, // arbitrary value
  parameter logic [7:0] IDENT_CODE = 8'h5A // arbitrary value
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic channel_select_n_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rd_valid_o,
  input wire logic rx_pin_i,
  input wire dur_pkg::dur_modem_in_s modem_i,
  output dur_pkg::dur_line_out_s line_o,
  output logic loopback_o,
  output logic auto_flow_active_o,
  output logic fifo_rx_reset_o,
  output logic fifo_tx_reset_o,
  output logic tx_load_o,
  output logic [7:0] tx_data_o,
  output logic rx_read_o,
  output logic rx_serial_o,
  input wire logic tx_serial_i,
  input wire logic [7:0] rx_data_i,
  input wire logic [5:0] int_source_i,
  input wire logic [7:0] line_status_i
);
  typedef struct packed {
    dur_pkg::dur_regs_s regs;
    dur_pkg::dur_modem_in_s modem_last;
    logic [3:0] modem_delta;
    dur_pkg::dur_line_out_s line;
    logic loop;
    logic auto_flow;
    logic [7:0] rdata;
    logic rd_valid;
    logic rx_rst;
    logic tx_rst;
    logic tx_load;
    logic [7:0] tx_data;
    logic rx_read;
    logic rx_serial;
  } dur_state_s;

  dur_state_s st;
  dur_state_s next_st;

  // access decode
  logic sel;
  logic rd_take;
  logic wr_take;
  logic enh_bank;
  logic div_bank;
  logic norm_bank;
  logic unlock;
  logic div_zero;
  logic loop_next;
  logic auto_flow_req;
  logic fifo_on;

  // enhanced-only bit masks
  logic [7:0] ien_mask;
  logic [7:0] istat_mask;
  logic [7:0] fcr_mask;
  logic [7:0] mctl_mask;

  // live output pin values before the loopback freeze, and modem input views after it
  dur_pkg::dur_line_out_s line_live;
  wire dur_pkg::dur_modem_in_s modem_eff;
  wire logic [3:0] modem_change;
  wire logic [3:0] modem_level;
  logic [7:0] modem_status;

  // equal codes would leave software unable to tell the two apart
  if (REVISION_CODE == IDENT_CODE)
  begin : g_code_check
    $error("revision and identification codes must differ");
  end

  // one cell per modem input; flag order runs opposite to the struct order
  for (genvar i = 0; i < 4; i++)
  begin : g_modem
    dur_modem_bit dur_modem_bit_i (
      .frozen_i(st.loop),
      .pin_n_i(modem_i[i]),
      .last_n_i(st.modem_last[i]),
      .level_n_o(modem_eff[i]),
      .change_o(modem_change[3 - i]),
      .level_o(modem_level[3 - i])
    );
  end

  always_comb
  begin
    sel = !channel_select_n_i;
    rd_take = sel && rd_i;
    wr_take = sel && wr_i && !rd_i;
    enh_bank = st.regs.lctl == dur_pkg::ENH_BANK_KEY;
    div_bank = st.regs.lctl[dur_pkg::LCTL_DIV_BIT] && !enh_bank;
    norm_bank = !st.regs.lctl[dur_pkg::LCTL_DIV_BIT];
    unlock = st.regs.enhanced_function[dur_pkg::EFR_UNLOCK_BIT];
    div_zero = st.regs.div_low == 8'h00 && st.regs.div_high == 8'h00;
    loop_next = st.regs.mctl[dur_pkg::MCTL_LOOP_BIT];
    auto_flow_req = st.regs.enhanced_function[dur_pkg::EFR_ARTS_BIT] || st.regs.enhanced_function[dur_pkg::EFR_ACTS_BIT];
    fifo_on = st.regs.fifo_control[dur_pkg::FCR_EN_BIT];
    // masks also apply on read, so bits left over from an unlocked phase read zero
    ien_mask = unlock ? 8'hFF : dur_pkg::IEN_BASE_MASK;
    istat_mask = unlock ? 8'hFF : dur_pkg::ISTAT_BASE_MASK;
    fcr_mask = unlock ? 8'hFF : dur_pkg::FCR_BASE_MASK;
    mctl_mask = unlock ? 8'hFF : dur_pkg::MCTL_BASE_MASK;
    modem_status = {modem_level, st.modem_delta};
  end

  always_comb
  begin
    line_live.tx = tx_serial_i && !st.regs.lctl[dur_pkg::LCTL_BREAK_BIT];
    line_live.rts_n = !st.regs.mctl[dur_pkg::MCTL_RTS_BIT];
    line_live.dtr_n = !st.regs.mctl[dur_pkg::MCTL_DTR_BIT];
    line_live.out1_n = !st.regs.mctl[dur_pkg::MCTL_OUT1_BIT];
    line_live.out2_n = !st.regs.mctl[dur_pkg::MCTL_OUT2_BIT];
  end

  always_comb
  begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    next_st.rx_rst = 1'b0;
    next_st.tx_rst = 1'b0;
    next_st.tx_load = 1'b0;
    next_st.rx_read = 1'b0;
    next_st.modem_last = modem_eff;
    // change flags: set wins over the clear caused by a read
    next_st.modem_delta = st.modem_delta | modem_change;
    next_st.loop = loop_next;
    next_st.auto_flow = !loop_next && auto_flow_req;
    // internal return path from transmit shift output to receiver
    next_st.rx_serial = loop_next ? tx_serial_i : rx_pin_i;
    // frozen pins keep the far side from seeing the test traffic
    if (!loop_next)
    begin
      next_st.line.tx = line_live.tx;
      next_st.line.dtr_n = line_live.dtr_n;
      next_st.line.rts_n = line_live.rts_n;
    end
    next_st.line.out1_n = line_live.out1_n;
    next_st.line.out2_n = line_live.out2_n;

    if (rd_take)
    begin
      next_st.rd_valid = 1'b1;
      next_st.rdata = 8'h00;
      unique case (addr_i)
        dur_pkg::ADDR_HOLD:
        begin
          if (div_bank)
            next_st.rdata = div_zero ? REVISION_CODE : st.regs.div_low;
          else if (!st.regs.lctl[dur_pkg::LCTL_DIV_BIT])
          begin
            next_st.rdata = rx_data_i;
            next_st.rx_read = 1'b1;
          end
        end
        dur_pkg::ADDR_IEN:
        begin
          if (div_bank)
            next_st.rdata = div_zero ? IDENT_CODE : st.regs.div_high;
          else if (norm_bank)
            next_st.rdata = st.regs.ien & ien_mask;
        end
        dur_pkg::ADDR_ISTAT:
        begin
          if (enh_bank)
            next_st.rdata = st.regs.enhanced_function;
          else if (div_bank && unlock)
            next_st.rdata = st.regs.frac;
          else
          begin
            next_st.rdata = {{2{fifo_on}}, int_source_i};
            next_st.rdata = next_st.rdata & istat_mask;
          end
        end
        dur_pkg::ADDR_LCTL:
          next_st.rdata = st.regs.lctl;
        dur_pkg::ADDR_MCTL:
          next_st.rdata = enh_bank ? st.regs.xon1 : (st.regs.mctl & mctl_mask);
        dur_pkg::ADDR_LSTAT:
          next_st.rdata = enh_bank ? st.regs.xon2 : line_status_i;
        dur_pkg::ADDR_MSTAT:
        begin
          if (enh_bank)
            next_st.rdata = st.regs.xoff1;
          else
          begin
            next_st.rdata = modem_status;
            next_st.modem_delta = modem_change;
          end
        end
        dur_pkg::ADDR_SCRATCH:
          next_st.rdata = enh_bank ? st.regs.xoff2 : st.regs.scratch;
      endcase
    end
    else if (wr_take)
    begin
      unique case (addr_i)
        dur_pkg::ADDR_HOLD:
        begin
          if (div_bank)
            next_st.regs.div_low = wdata_i;
          else if (!st.regs.lctl[dur_pkg::LCTL_DIV_BIT])
          begin
            next_st.tx_data = wdata_i;
            next_st.tx_load = 1'b1;
          end
        end
        dur_pkg::ADDR_IEN:
        begin
          if (div_bank)
            next_st.regs.div_high = wdata_i;
          else if (!st.regs.lctl[dur_pkg::LCTL_DIV_BIT])
            next_st.regs.ien = wdata_i & ien_mask;
        end
        dur_pkg::ADDR_ISTAT:
        begin
          if (enh_bank)
            next_st.regs.enhanced_function = wdata_i;
          else if (div_bank)
          begin
            if (unlock)
              next_st.regs.frac = wdata_i & dur_pkg::FRAC_MASK;
          end
          else
          begin
            next_st.regs.fifo_control = wdata_i & fcr_mask;
            // fifo reset bits are pulses and are never kept
            next_st.rx_rst = wdata_i[dur_pkg::FCR_RXRST_BIT];
            next_st.tx_rst = wdata_i[dur_pkg::FCR_TXRST_BIT];
            next_st.regs.fifo_control[dur_pkg::FCR_RXRST_BIT] = 1'b0;
            next_st.regs.fifo_control[dur_pkg::FCR_TXRST_BIT] = 1'b0;
          end
        end
        dur_pkg::ADDR_LCTL:
          next_st.regs.lctl = wdata_i;
        dur_pkg::ADDR_MCTL:
        begin
          if (enh_bank)
            next_st.regs.xon1 = wdata_i;
          else
            next_st.regs.mctl = wdata_i & mctl_mask;
        end
        dur_pkg::ADDR_LSTAT:
        begin
          if (enh_bank)
            next_st.regs.xon2 = wdata_i; // line status itself is read-only
        end
        dur_pkg::ADDR_MSTAT:
        begin
          if (enh_bank)
            next_st.regs.xoff1 = wdata_i;
        end
        dur_pkg::ADDR_SCRATCH:
        begin
          if (enh_bank)
            next_st.regs.xoff2 = wdata_i;
          else
            next_st.regs.scratch = wdata_i;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.regs.ien <= dur_pkg::ZERO_RESET;
      st.regs.fifo_control <= dur_pkg::ZERO_RESET;
      st.regs.mctl <= dur_pkg::ZERO_RESET;
      st.regs.scratch <= dur_pkg::ZERO_RESET;
      st.regs.enhanced_function <= dur_pkg::ZERO_RESET;
      st.regs.lctl <= dur_pkg::LCTL_RESET;
      st.regs.div_low <= dur_pkg::DIV_LOW_RESET;
      st.regs.div_high <= dur_pkg::DIV_HIGH_RESET;
      st.regs.frac <= dur_pkg::FRAC_RESET;
      st.regs.xon1 <= dur_pkg::CHAR_RESET;
      st.regs.xon2 <= dur_pkg::CHAR_RESET;
      st.regs.xoff1 <= dur_pkg::CHAR_RESET;
      st.regs.xoff2 <= dur_pkg::CHAR_RESET;
      st.rdata <= dur_pkg::ZERO_RESET;
      st.tx_data <= dur_pkg::ZERO_RESET;
      st.modem_delta <= 4'h0;
      st.rd_valid <= 1'b0;
      st.rx_rst <= 1'b0;
      st.tx_rst <= 1'b0;
      st.tx_load <= 1'b0;
      st.rx_read <= 1'b0;
      st.loop <= 1'b0;
      st.auto_flow <= 1'b0;
      // pins idle inactive and the receive stream idles at mark
      st.modem_last <= '1;
      st.line <= '1;
      st.rx_serial <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign rd_valid_o = st.rd_valid;
  assign line_o = st.line;
  assign loopback_o = st.loop;
  assign auto_flow_active_o = st.auto_flow;
  assign fifo_rx_reset_o = st.rx_rst;
  assign fifo_tx_reset_o = st.tx_rst;
  assign tx_load_o = st.tx_load;
  assign tx_data_o = st.tx_data;
  assign rx_read_o = st.rx_read;
  assign rx_serial_o = st.rx_serial;
endmodule : dur_channel

// one modem input: frozen in loopback, change flag against the last kept level
module dur_modem_bit #(
  parameter bit ACTIVE_LOW = 1'b1
) (
  input wire logic frozen_i,
  input wire logic pin_n_i,
  input wire logic last_n_i,
  output logic level_n_o,
  output logic change_o,
  output logic level_o
);

  always_comb
  begin
    level_n_o = frozen_i ? last_n_i : pin_n_i;
    change_o = last_n_i ^ level_n_o;
    level_o = level_n_o ^ ACTIVE_LOW;
  end
endmodule : dur_modem_bit
`default_nettype wire

/* File: testbench/dur_serial_peer.sv */
// partner model: serial peer and receive-side data sources of one channel
`timescale 1ns/1ns
`default_nettype none
module dur_serial_peer (
  input wire logic core_clk_i,
  input wire logic rst_i,
  output logic rx_pin_o,
  output var dur_pkg::dur_modem_in_s modem_o,
  output logic tx_serial_o,
  output logic [7:0] rx_data_o,
  output logic [5:0] int_source_o,
  output logic [7:0] line_status_o
);
  logic [3:0] pat;
  // moving pattern on transmitter stream and modem pins
  always_ff @(posedge core_clk_i)
  begin
    pat <= rst_i ? 4'h9 : {pat[2:0], pat[3]};
  end
  assign rx_pin_o = 1'b1;
  assign modem_o = pat;
  assign tx_serial_o = pat[3];
  assign rx_data_o = 8'hC5;
  assign int_source_o = 6'h31;
  assign line_status_o = 8'h61;
endmodule : dur_serial_peer
`default_nettype wire

/* File: testbench/dur_channel_sva.sv */
// checker: port-level assertions of the channel register bank
`timescale 1ns/1ns
`default_nettype none
module dur_channel_sva (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic channel_select_n_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_valid_o,
  input wire logic rx_pin_i,
  input wire dur_pkg::dur_line_out_s line_o,
  input wire logic loopback_o,
  input wire logic auto_flow_active_o,
  input wire logic fifo_rx_reset_o,
  input wire logic tx_load_o,
  input wire logic [7:0] tx_data_o,
  input wire logic rx_serial_o,
  input wire logic tx_serial_i
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence take_read;
    !channel_select_n_i && rd_i;
  endsequence
  sequence loop_steady;
    loopback_o && $past(loopback_o);
  endsequence
  chk_read_answer: assert property (take_read |=> rd_valid_o)
    else $error("read not answered");
  chk_valid_cause: assert property (rd_valid_o |-> $past(!channel_select_n_i && rd_i))
    else $error("read valid without read");
  chk_tx_load: assert property (tx_load_o |-> tx_data_o == $past(wdata_i)
    && $past(wr_i && !rd_i && !channel_select_n_i && addr_i == dur_pkg::ADDR_HOLD))
    else $error("bad transmit load");
  chk_rx_fifo_reset: assert property (fifo_rx_reset_o
    |-> $past(wr_i && !rd_i && !channel_select_n_i && addr_i == dur_pkg::ADDR_ISTAT && wdata_i[1]))
    else $error("bad receive reset");
  chk_loop_route: assert property (loop_steady |-> rx_serial_o == $past(tx_serial_i))
    else $error("loop stream wrong");
  chk_pins_hold: assert property (loop_steady |-> $stable(line_o.tx)
    && $stable(line_o.rts_n) && $stable(line_o.dtr_n))
    else $error("pins moved in loop");
  chk_flow_off: assert property (loop_steady |-> !auto_flow_active_o)
    else $error("flow active in loop");
  chk_normal_route: assert property (!loopback_o && !$past(loopback_o)
    |-> rx_serial_o == $past(rx_pin_i))
    else $error("receive stream wrong");
endmodule : dur_channel_sva
bind dur_channel dur_channel_sva dur_channel_sva_i (.core_clk_i, .rst_i, .channel_select_n_i, .addr_i,
  .rd_i, .wr_i, .wdata_i, .rd_valid_o, .rx_pin_i, .line_o, .loopback_o, .auto_flow_active_o,
  .fifo_rx_reset_o, .tx_load_o, .tx_data_o, .rx_serial_o, .tx_serial_i);
`default_nettype wire

/* File: testbench/testbench.sv */
// testbench: register bank and loopback scenarios of one channel
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [7:0] REV = 8'h3C; // arbitrary value
  localparam logic [7:0] IDC = 8'hC3; // arbitrary value
  logic core_clk_i, rst_i, sel_n, rd, wr, rx_pin, tx_ser, rd_valid, loop, flow;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rx_data, lstat, tx_data;
  logic [5:0] isrc;
  dur_pkg::dur_modem_in_s modem;
  dur_pkg::dur_line_out_s line;
  int miscompares = 0;
  int checks = 0;
  dur_channel #(.REVISION_CODE(REV), .IDENT_CODE(IDC)) dur_channel_i (.core_clk_i, .rst_i,
    .channel_select_n_i(sel_n), .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata),
    .rd_valid_o(rd_valid), .rx_pin_i(rx_pin), .modem_i(modem), .line_o(line), .loopback_o(loop),
    .auto_flow_active_o(flow), .fifo_rx_reset_o(), .fifo_tx_reset_o(), .tx_load_o(), .tx_data_o(tx_data),
    .rx_read_o(), .rx_serial_o(), .tx_serial_i(tx_ser), .rx_data_i(rx_data), .int_source_i(isrc),
    .line_status_i(lstat));
  dur_serial_peer dur_serial_peer_i (.core_clk_i, .rst_i, .rx_pin_o(rx_pin), .modem_o(modem),
    .tx_serial_o(tx_ser), .rx_data_o(rx_data), .int_source_o(isrc), .line_status_o(lstat));
  initial
  begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    sel_n <= 1'b0;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
    sel_n <= 1'b1;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge core_clk_i);
    sel_n <= 1'b0;
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    sel_n <= 1'b1;
    #1;
    cmp({7'h00, rd_valid}, 8'h01);
    cmp(rdata & m, e);
  endtask : rd_reg
  task automatic give_verdict();
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    #40000;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    rst_i = 1'b1;
    sel_n = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd_reg(3'h3, 8'h03);
    rd_reg(3'h4, 8'h00);
    rd_reg(3'h6, 8'h0F, 8'h0F);
    wr_reg(3'h1, 8'hFF);
    rd_reg(3'h1, 8'h0F);
    wr_reg(3'h7, 8'hA5);
    rd_reg(3'h7, 8'hA5);
    wr_reg(3'h2, 8'h07);
    rd_reg(3'h2, 8'hC1);
    wr_reg(3'h0, 8'h5A);
    #1 cmp(tx_data, 8'h5A);
    rd_reg(3'h0, 8'hC5);
    wr_reg(3'h5, 8'h00);
    rd_reg(3'h5, 8'h61);
    wr_reg(3'h3, 8'h80);
    rd_reg(3'h0, 8'h01);
    wr_reg(3'h0, 8'h00);
    rd_reg(3'h0, REV);
    rd_reg(3'h1, IDC);
    wr_reg(3'h0, 8'h12);
    rd_reg(3'h0, 8'h12);
    wr_reg(3'h2, 8'hFF);
    wr_reg(3'h3, 8'hBF);
    wr_reg(3'h2, 8'hD0);
    rd_reg(3'h2, 8'hD0);
    for (int a = 4; a < 8; a++)
    begin
      wr_reg(3'(a), 8'h10 + 8'(a));
      rd_reg(3'(a), 8'h10 + 8'(a));
    end
    wr_reg(3'h3, 8'h80);
    rd_reg(3'h2, 8'h00);
    wr_reg(3'h2, 8'hFF);
    rd_reg(3'h2, 8'h3F);
    wr_reg(3'h3, 8'h03);
    wr_reg(3'h1, 8'hFF);
    rd_reg(3'h1, 8'hFF);
    rd_reg(3'h2, 8'hF1);
    cmp({7'h00, flow}, 8'h01);
    wr_reg(3'h4, 8'h0F);
    repeat (2) @(posedge core_clk_i);
    #1 cmp({4'h0, line.rts_n, line.dtr_n, line.out1_n, line.out2_n}, 8'h00);
    wr_reg(3'h3, 8'h43);
    repeat (2) @(posedge core_clk_i);
    #1 cmp({7'h00, line.tx}, 8'h00);
    wr_reg(3'h3, 8'h03);
    wr_reg(3'h4, 8'h13);
    wr_reg(3'h4, 8'h10);
    repeat (2) @(posedge core_clk_i);
    #1 cmp({loop, line.rts_n, line.dtr_n}, 3'h4);
    rd_reg(3'h5, 8'h61);
    rd_reg(3'h6, 8'h0F, 8'h0F);
    rd_reg(3'h6, 8'h00, 8'h0F);
    wr_reg(3'h4, 8'h00);
    repeat (2) @(posedge core_clk_i);
    #1 cmp({loop, line.rts_n, line.dtr_n}, 3'h3);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
